// ==== verilog/umd_receiver.sv ====
// Behaviour
// - falling edge starts count, centre sample validates
// - data and stop sampled at centre, framing
// - parity, framing, break follow head; overrun held until status read
// - timeout after four words plus twelve bits
// - data interrupt tracks trigger level
// - ready bit set on push, clear when empty
// - multidrop bit with detect off: normal mode
// - receiver off: drop data, keep addresses flagged
// - receiver on: keep all, addresses interrupt
// - auto mode compares with second pause character
// - matching address enables, stored, interrupts
// - mismatching address disables, data ignored
// - divisor registers visible only with access bit
// - direction pin polarity from mode bit seven
// - flow chars with parity error: mode bit five
// - infrared pulse width from mode bit four
// - line status bits five to seven
// - mask bits seven, six: handshake rising edges
// - mask bit five: pause character interrupt
// - mask bit three: modem delta interrupt
// - reads clear timeout and line interrupts
// - errored char interrupts again at head
`timescale 1ns/10ps
`default_nettype none
module umd_receiver (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  host_addr,
  input  wire logic [7:0]  host_wdata,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  output logic      [7:0]  host_rdata,
  input  wire logic        serial_in,
  input  wire logic        cts_pin_n,
  input  wire logic        rts_level,
  input  wire logic        tx_active,
  input  wire logic        tx_holding_empty,
  input  wire logic        tx_all_empty,
  input  wire logic [3:0]  modem_delta,
  input  wire logic [1:0]  sample_mode,
  input  wire logic        baud_tick,
  output logic      [15:0] divisor,
  output logic      [3:0]  frac_divisor,
  output logic             dir_pin,
  output logic             ir_quarter_width,
  output logic             pause_received,
  output logic             resume_received,
  output logic             irq
);
  typedef struct packed {
    logic [2:0]             rx_sync;
    logic                   rx_f;
    logic                   rx_last;
    logic [2:0]             cts_sync;
    logic                   cts_f;
    logic                   cts_last;
    logic                   rts_last;
    umd_pkg::umd_rx_state_e st;
    logic [3:0]             cnt;
    logic [2:0]             bitn;
    logic [7:0]             shift;
    logic                   par;
    logic [7:0]             line_control, interrupt_mask, enhanced_function_control, dll, divisor_high_byte, fractional_divisor_and_mode;
    logic [7:0]             pause1, pause2, resume1, rx_trig;
    logic                   fifo_en;
    logic                   rx_disable;
    logic [7:0]             wr_ptr, rd_ptr;
    logic [8:0]             level;
    logic [8:0]             err_count;
    logic                   popped;
    logic                   overrun, lsr_int, tmo_flag;
    logic                   pause_int, cts_int, rts_int;
    logic [3:0]             delta;
    logic                   pause_det, resume_det;
    logic                   pause_evt, resume_evt;
    logic [3:0]             tmo_sub;
    logic [5:0]             tmo_bits;
    logic                   cand_valid;
    logic [10:0]            cand;
    logic                   dir;
    logic [7:0]             rdata;
  } umd_state_s;

  function automatic logic [3:0] last_tick(input logic [1:0] m);
    last_tick = (m == 2'd0) ? 4'd15 : (m == 2'd1) ? 4'd7 : 4'd3;
  endfunction : last_tick

  function automatic logic [3:0] half_tick(input logic [1:0] m);
    half_tick = (m == 2'd0) ? 4'd7 : (m == 2'd1) ? 4'd3 : 4'd1;
  endfunction : half_tick

  function automatic logic [7:0] align(input logic [7:0] sh,
                                       input logic [1:0] wl);
    unique case (wl)
      2'd0: align = {3'b000, sh[7:3]};
      2'd1: align = {2'b00, sh[7:2]};
      2'd2: align = {1'b0, sh[7:1]};
      2'd3: align = sh;
    endcase
  endfunction : align

  function automatic logic parity_ok(input logic [7:0] d, input logic p,
                                     input logic [7:0] lc);
    if (!lc[3]) parity_ok = 1'b1;
    else if (lc[5]) parity_ok = (p == ~lc[4]);
    else parity_ok = ((^d ^ p) == ~lc[4]);
  endfunction : parity_ok

  ////////////////////////////////////////////////////////////////////////
  logic [1:0]  rst_q;
  logic        rst_n;
  umd_state_s  s;
  umd_state_s  next_s;
  logic [10:0] rx_mem [umd_pkg::FIFO_DEPTH];
  logic [10:0] head;
  logic        dlab, fall, samp, char_done;
  logic [7:0]  ch_data;
  logic        ch_par, perr, md_on, md_auto, addr, match, keep;
  logic [10:0] ch;
  logic [8:0]  trig;
  logic        tmo_active, tmo_hit, fifo_push, pop, lsr_set;
  logic        rd_hold, rd_lsr, rd_src, rd_modem, rd_flow, mask_wr;
  logic [5:0]  tmo_limit, src_code;
  logic [7:0]  rd_val;
  logic        src_line, src_rx, src_tmo, src_modem, src_pause, src_hs;

  umd_stream_if in_s ();
  umd_stream_if out_s ();

  umd_skid_buffer u_buf (
    .clk   (mclk),
    .rst_n (rst_n),
    .up    (in_s.snk),
    .dn    (out_s.src)
  );

  // release only: assertion stays asynchronous
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) rst_q <= 2'b00;
    else rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  assign dlab      = s.line_control[7];
  assign head      = rx_mem[s.rd_ptr];
  assign fall      = s.rx_last && !s.rx_f;
  assign samp      = baud_tick && (s.st != umd_pkg::ST_IDLE) &&
                     (s.cnt == ((s.st == umd_pkg::ST_START) ?
                      half_tick(sample_mode) : last_tick(sample_mode)));
  assign char_done = samp && (s.st == umd_pkg::ST_STOP);
  assign ch_data   = align(s.shift, s.line_control[1:0]);
  assign ch_par    = s.line_control[3] && s.par;
  assign perr      = !parity_ok(ch_data, ch_par, s.line_control);
  assign md_on     = s.fractional_divisor_and_mode[6];
  assign md_auto   = md_on && s.enhanced_function_control[5];
  assign addr      = md_on && ch_par;
  assign match     = (ch_data == s.pause2);
  // auto mode stores the raw parity bit in the error slot for address bytes; data bytes keep the parity check
  assign ch        = {(ch_data == 8'h00) && !ch_par && !s.rx_f, !s.rx_f,
                      (md_auto && addr) ? ch_par : perr, ch_data};
  assign keep      = !md_on || (md_auto ? (addr ? match : !s.rx_disable)
                      : (addr || !s.rx_disable));
  assign trig      = {1'b0, (!s.fifo_en || s.rx_trig == 8'h00) ? 8'h01
                      : s.rx_trig};
  assign tmo_limit = 6'(umd_pkg::TMO_WORDS * (6'd5 + {4'b0, s.line_control[1:0]}))
                     + umd_pkg::TMO_EXTRA;
  assign tmo_active = (s.level != 9'd0) && (s.level < trig) &&
                      (s.st == umd_pkg::ST_IDLE);
  // one pulse as the last bit time ends; the count then parks, so a
  // host read of the holding byte is not overridden by a standing hit
  assign tmo_hit   = tmo_active && baud_tick &&
                     (s.tmo_sub == last_tick(sample_mode)) &&
                     (s.tmo_bits == tmo_limit - 6'd1);
  assign fifo_push = out_s.valid && out_s.ready;
  assign pop       = rd_hold && (s.level != 9'd0);
  assign rd_hold   = host_rd && host_addr == umd_pkg::OFS_HOLD && !dlab;
  assign rd_lsr    = host_rd && host_addr == umd_pkg::OFS_LINE_ST;
  assign rd_src    = host_rd && host_addr == umd_pkg::OFS_SRC && !dlab;
  assign rd_modem  = host_rd && host_addr == umd_pkg::OFS_MODEM;
  assign rd_flow   = host_rd && host_addr == umd_pkg::OFS_PAUSE1;
  assign mask_wr   = host_wr && host_addr == umd_pkg::OFS_MASK && !dlab;
  // second pass when an errored byte becomes the head
  assign lsr_set   = (fifo_push && |out_s.data[10:8]) ||
                     (s.cand_valid && !in_s.ready) ||
                     (s.popped && s.level != 9'd0 && |head[10:8]);

  assign in_s.valid   = s.cand_valid;
  assign in_s.data    = s.cand;
  assign out_s.ready  = (s.level < 9'(umd_pkg::FIFO_DEPTH));

  assign src_line  = s.interrupt_mask[2] && s.lsr_int;
  assign src_rx    = s.interrupt_mask[0] && (s.level >= trig);
  assign src_tmo   = s.interrupt_mask[0] && s.tmo_flag;
  assign src_modem = s.interrupt_mask[3] && (s.delta != 4'h0);
  assign src_pause = s.interrupt_mask[5] && s.pause_int;
  assign src_hs    = (s.interrupt_mask[7] && s.cts_int) || (s.interrupt_mask[6] && s.rts_int);
  assign irq       = src_line || src_rx || src_tmo || src_modem ||
                     src_pause || src_hs;
  assign src_code  = src_line ? umd_pkg::SRC_LINE :
                     src_rx ? umd_pkg::SRC_RXDATA :
                     src_tmo ? umd_pkg::SRC_TMO :
                     src_modem ? umd_pkg::SRC_MODEM :
                     src_pause ? umd_pkg::SRC_PAUSE :
                     src_hs ? umd_pkg::SRC_HSHAKE : umd_pkg::SRC_NONE;

  always_comb begin
    unique case (host_addr)
      umd_pkg::OFS_HOLD:     rd_val = dlab ? s.dll : head[7:0];
      umd_pkg::OFS_MASK:     rd_val = dlab ? s.divisor_high_byte : s.interrupt_mask;
      umd_pkg::OFS_SRC:      rd_val = dlab ? s.fractional_divisor_and_mode
                                     : {s.fifo_en, s.fifo_en, src_code};
      umd_pkg::OFS_LINE_CTL: rd_val = s.line_control;
      umd_pkg::OFS_LINE_ST:  rd_val = {s.err_count != 9'd0, tx_all_empty,
                                       tx_holding_empty,
                                       head[10:8] & {3{s.level != 9'd0}},
                                       s.overrun,
                                       s.level != 9'd0};
      umd_pkg::OFS_MODEM:    rd_val = {2'b00, s.rts_int, s.cts_int, s.delta};
      umd_pkg::OFS_ENH:      rd_val = s.enhanced_function_control;
      umd_pkg::OFS_RX_LEVEL: rd_val = s.level[8] ? 8'hFF : s.level[7:0];
      umd_pkg::OFS_PAUSE1:   rd_val = {6'h00, s.resume_det, s.pause_det};
      default:               rd_val = umd_pkg::REG_RESET;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.rx_sync = {s.rx_sync[1:0], serial_in};
    if (s.rx_sync[1] == s.rx_sync[2]) next_s.rx_f = s.rx_sync[2];
    next_s.rx_last = s.rx_f;
    next_s.cts_sync = {s.cts_sync[1:0], cts_pin_n};
    if (s.cts_sync[1] == s.cts_sync[2]) next_s.cts_f = s.cts_sync[2];
    next_s.cts_last = s.cts_f;
    next_s.rts_last = rts_level;
    next_s.dir = tx_active ^ s.fractional_divisor_and_mode[7];
    next_s.cand_valid = 1'b0;
    next_s.pause_evt = 1'b0;
    next_s.resume_evt = 1'b0;
    next_s.popped = pop;
    if (host_rd) next_s.rdata = rd_val;

    if (host_wr) begin
      unique case (host_addr)
        umd_pkg::OFS_HOLD: if (dlab) next_s.dll = host_wdata;
        umd_pkg::OFS_MASK: begin
          if (dlab) begin
            next_s.divisor_high_byte = host_wdata;
          end else begin
            next_s.interrupt_mask[3:0] = host_wdata[3:0];
            if (s.enhanced_function_control[4]) next_s.interrupt_mask[7:5] = host_wdata[7:5];
          end
        end
        umd_pkg::OFS_SRC: begin
          if (dlab) next_s.fractional_divisor_and_mode = host_wdata;
          else next_s.fifo_en = host_wdata[0];
        end
        umd_pkg::OFS_LINE_CTL: next_s.line_control = host_wdata;
        umd_pkg::OFS_MODEM:    next_s.rx_disable = host_wdata[2];
        umd_pkg::OFS_ENH:      next_s.enhanced_function_control = host_wdata;
        umd_pkg::OFS_RX_LEVEL: next_s.rx_trig = host_wdata;
        umd_pkg::OFS_PAUSE1:   next_s.pause1 = host_wdata;
        umd_pkg::OFS_PAUSE2:   next_s.pause2 = host_wdata;
        umd_pkg::OFS_RESUME1:  next_s.resume1 = host_wdata;
        default:               next_s.rdata = s.rdata;
      endcase
    end

    if (baud_tick && !samp && s.st != umd_pkg::ST_IDLE)
      next_s.cnt = s.cnt + 4'd1;
    unique case (s.st)
      umd_pkg::ST_IDLE: begin
        if (fall) begin
          next_s.st = umd_pkg::ST_START;
          next_s.cnt = 4'd0;
        end
      end
      umd_pkg::ST_START: begin
        if (samp) begin
          next_s.cnt = 4'd0;
          next_s.bitn = 3'd0;
          next_s.par = 1'b0;
          next_s.st = s.rx_f ? umd_pkg::ST_IDLE : umd_pkg::ST_DATA;
        end
      end
      umd_pkg::ST_DATA: begin
        if (samp) begin
          next_s.cnt = 4'd0;
          next_s.shift = {s.rx_f, s.shift[7:1]};
          next_s.bitn = s.bitn + 3'd1;
          if (s.bitn == 3'd4 + {1'b0, s.line_control[1:0]})
            next_s.st = s.line_control[3] ? umd_pkg::ST_PARITY : umd_pkg::ST_STOP;
        end
      end
      umd_pkg::ST_PARITY: begin
        if (samp) begin
          next_s.cnt = 4'd0;
          next_s.par = s.rx_f;
          next_s.st = umd_pkg::ST_STOP;
        end
      end
      umd_pkg::ST_STOP: begin
        if (samp) next_s.st = umd_pkg::ST_IDLE;
      end
      default: next_s.st = umd_pkg::ST_IDLE;
    endcase

    if (char_done) begin
      next_s.cand_valid = keep;
      next_s.cand = ch;
      if (md_auto && addr) next_s.rx_disable = !match;
      if (!md_on && (!perr || !s.fractional_divisor_and_mode[5])) begin
        next_s.pause_evt = (ch_data == s.pause1);
        next_s.resume_evt = (ch_data == s.resume1);
      end
    end

    // flow flags self-clear on read; a new detection wins
    next_s.pause_det = (s.pause_det && !rd_flow) || s.pause_evt;
    next_s.resume_det = (s.resume_det && !rd_flow) || s.resume_evt;
    next_s.pause_int = (s.pause_int && !rd_src) || s.pause_evt;
    next_s.cts_int = (s.cts_int && !rd_modem) ||
                     (s.interrupt_mask[7] && s.cts_f && !s.cts_last);
    next_s.rts_int = (s.rts_int && !rd_modem) ||
                     (s.interrupt_mask[6] && rts_level && !s.rts_last);
    next_s.delta = (s.delta & {4{!rd_modem}}) | modem_delta;
    next_s.overrun = (s.overrun && !rd_lsr) ||
                     (s.cand_valid && !in_s.ready);
    next_s.lsr_int = (s.lsr_int && !rd_lsr) || lsr_set;
    next_s.tmo_flag = (s.tmo_flag && !rd_hold) || tmo_hit;

    if (!tmo_active || fifo_push || pop) begin
      next_s.tmo_sub = 4'd0;
      next_s.tmo_bits = 6'd0;
    end else if (baud_tick) begin
      if (s.tmo_sub == last_tick(sample_mode)) begin
        next_s.tmo_sub = 4'd0;
        if (s.tmo_bits != tmo_limit) next_s.tmo_bits = s.tmo_bits + 6'd1;
      end else begin
        next_s.tmo_sub = s.tmo_sub + 4'd1;
      end
    end

    if (fifo_push) next_s.wr_ptr = s.wr_ptr + 8'd1;
    if (pop) next_s.rd_ptr = s.rd_ptr + 8'd1;
    next_s.level = s.level + {8'd0, fifo_push} - {8'd0, pop};
    next_s.err_count = s.err_count + {8'd0, fifo_push && |out_s.data[10:8]}
                       - {8'd0, pop && |head[10:8]};
    if (host_wr && host_addr == umd_pkg::OFS_SRC && !dlab &&
        host_wdata[1]) begin
      next_s.wr_ptr = 8'd0;
      next_s.rd_ptr = 8'd0;
      next_s.level = 9'd0;
      next_s.err_count = 9'd0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.rx_sync <= umd_pkg::SYNC_RESET;
      s.cts_sync <= umd_pkg::SYNC_RESET;
      s.rx_f <= 1'b1;
      s.rx_last <= 1'b1;
      s.cts_f <= 1'b1;
      s.cts_last <= 1'b1;
      s.rts_last <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // storage only, no reset: pointers decide what is valid
  always_ff @(posedge mclk) begin
    if (fifo_push) rx_mem[s.wr_ptr] <= out_s.data;
  end

  assign host_rdata       = s.rdata;
  assign divisor          = {s.divisor_high_byte, s.dll};
  assign frac_divisor     = s.fractional_divisor_and_mode[3:0];
  assign dir_pin          = s.dir;
  assign ir_quarter_width = s.fractional_divisor_and_mode[4];
  assign pause_received   = s.pause_evt;
  assign resume_received  = s.resume_evt;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_start_reject: assert property (
    (s.st == umd_pkg::ST_START && samp && s.rx_f) |=>
    (s.st == umd_pkg::ST_IDLE && !s.cand_valid))
    else $error("false start not discarded");
  a_start_accept: assert property (
    (s.st == umd_pkg::ST_START && samp && !s.rx_f) |=>
    s.st == umd_pkg::ST_DATA) else $error("valid start not taken");
  a_stop_frame: assert property (
    (char_done && !s.rx_f && keep) |=> (s.cand_valid && s.cand[9]))
    else $error("framing error not marked");
  a_head_flags: assert property (
    (rd_lsr && s.level != 9'd0) |=> host_rdata[4:2] == $past(head[10:8]))
    else $error("error flags do not follow head");
  a_ready_bit: assert property (
    rd_lsr |=> host_rdata[0] == ($past(s.level) != 9'd0))
    else $error("ready bit wrong");
  a_err_summary: assert property (
    rd_lsr |=> host_rdata[7] == ($past(s.err_count) != 9'd0))
    else $error("fifo error summary wrong");
  a_tmo_clear: assert property (
    (rd_hold && !tmo_hit) |=> !s.tmo_flag)
    else $error("timeout not cleared by read");
  a_line_clear: assert property (
    (rd_lsr && !lsr_set) |=> !s.lsr_int)
    else $error("line interrupt not cleared by read");
  a_overrun_set: assert property (
    (s.cand_valid && !in_s.ready) |=> s.overrun)
    else $error("lost character without overrun");
  a_auto_match: assert property (
    (char_done && md_auto && addr && match) |=>
    (!s.rx_disable && s.cand_valid && s.cand[8]))
    else $error("matching address not taken");
  a_auto_drop: assert property (
    (char_done && md_auto && addr && !match) |=>
    (s.rx_disable && !s.cand_valid))
    else $error("foreign address not dropped");
  a_normal_drop: assert property (
    (char_done && md_on && !md_auto && !addr && s.rx_disable) |=>
    !s.cand_valid) else $error("data kept while receiver off");
  a_access_gate: assert property (
    (host_rd && host_addr == umd_pkg::OFS_HOLD && dlab) |=>
    host_rdata == $past(s.dll)) else $error("divisor not shown");
  a_mask_lock: assert property (
    (mask_wr && !s.enhanced_function_control[4]) |=> s.interrupt_mask[7:5] == $past(s.interrupt_mask[7:5]))
    else $error("locked mask bits changed");
  a_rx_irq: assert property (
    (s.interrupt_mask[0] && s.fifo_en && s.level >= trig) |-> irq)
    else $error("data interrupt missing at trigger");

  c_char_stored: cover property (fifo_push ##1 rd_hold);
  c_auto_match: cover property (char_done && md_auto && addr && match);
  c_timeout: cover property (tmo_hit);
endmodule : umd_receiver
`default_nettype wire

// ==== pkg/umd_pkg.sv ====
`default_nettype none
package umd_pkg;
  // host offsets on the 4-bit address pins
  localparam logic [3:0] OFS_HOLD     = 4'h0; // holding byte / div low
  localparam logic [3:0] OFS_MASK     = 4'h1; // interrupt mask / div high
  localparam logic [3:0] OFS_SRC      = 4'h2; // source code / fifo ctl / frac
  localparam logic [3:0] OFS_LINE_CTL = 4'h3;
  localparam logic [3:0] OFS_LINE_ST  = 4'h5;
  localparam logic [3:0] OFS_MODEM    = 4'h6;
  localparam logic [3:0] OFS_ENH      = 4'h9;
  localparam logic [3:0] OFS_RX_LEVEL = 4'hB; // read level, write trigger
  localparam logic [3:0] OFS_PAUSE1   = 4'hC; // write char, read flow flags
  localparam logic [3:0] OFS_PAUSE2   = 4'hD;
  localparam logic [3:0] OFS_RESUME1  = 4'hE;

  localparam int unsigned FIFO_DEPTH = 256;
  localparam int unsigned ENTRY_W    = 11;
  localparam int unsigned ENT_PERR   = 8;
  localparam int unsigned ENT_FERR   = 9;
  localparam int unsigned ENT_BRK    = 10;

  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'b111;

  // idle gap: four words plus twelve bit times
  localparam logic [5:0] TMO_WORDS = 6'h04;
  localparam logic [5:0] TMO_EXTRA = 6'h0C;

  // source codes, most urgent first
  localparam logic [5:0] SRC_LINE   = 6'h06;
  localparam logic [5:0] SRC_RXDATA = 6'h04;
  localparam logic [5:0] SRC_TMO    = 6'h0C;
  localparam logic [5:0] SRC_MODEM  = 6'h00;
  localparam logic [5:0] SRC_PAUSE  = 6'h10;
  localparam logic [5:0] SRC_HSHAKE = 6'h20;
  localparam logic [5:0] SRC_NONE   = 6'h01;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP   = 3'b100
  } umd_rx_state_e;
endpackage : umd_pkg
`default_nettype wire

// ==== pkg/umd_stream_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface umd_stream_if;
  logic                         valid;
  logic                         ready;
  logic [umd_pkg::ENTRY_W-1:0]  data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : umd_stream_if
`default_nettype wire

// ==== verilog/umd_skid_buffer.sv ====
`timescale 1ns/10ps
`default_nettype none
module umd_skid_buffer (
  input  wire logic   clk,
  input  wire logic   rst_n,
  umd_stream_if.snk   up,
  umd_stream_if.src   dn
);
  typedef struct packed {
    logic [1:0]                  count;
    logic [umd_pkg::ENTRY_W-1:0] e0;
    logic [umd_pkg::ENTRY_W-1:0] e1;
  } umd_buf_s;

  umd_buf_s s;
  umd_buf_s next_s;
  logic     push;
  logic     pop;

  assign up.ready = (s.count != 2'd2);
  assign dn.valid = (s.count != 2'd0);
  assign dn.data  = s.e0;
  assign push     = up.valid && up.ready;
  assign pop      = dn.valid && dn.ready;

  always_comb begin
    next_s = s;
    unique case ({push, pop})
      2'b10: begin
        if (s.count == 2'd0) next_s.e0 = up.data;
        else next_s.e1 = up.data;
        next_s.count = s.count + 2'd1;
      end
      2'b01: begin
        next_s.e0 = s.e1;
        next_s.count = s.count - 2'd1;
      end
      2'b11: begin
        if (s.count == 2'd1) begin
          next_s.e0 = up.data;
        end else begin
          next_s.e0 = s.e1;
          next_s.e1 = up.data;
        end
      end
      2'b00: next_s = s;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) s <= '0;
    else s <= next_s;
  end

  a_buf_bound: assert property (@(posedge clk) disable iff (!rst_n)
    s.count <= 2'd2) else $error("buffer count above two");
  a_buf_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (dn.valid && !dn.ready) |=> (dn.valid && $stable(dn.data)))
    else $error("stalled head word changed");
endmodule : umd_skid_buffer
`default_nettype wire

// ==== tb/umd_serial_station.sv ====
`timescale 1ns/10ps
`default_nettype none
module umd_serial_station (
  input  wire logic mclk,
  output logic      line
);
  // idle line rests high, as with a pull-up
  initial line = 1'b1;
  ////////////////////////////////////////
  // one bit is 8 mclk: 4x mode with a tick every second cycle
  task automatic bit_out(input logic v);
    line <= v;
    repeat (8) @(posedge mclk);
  endtask : bit_out
  task automatic send(input logic [7:0] d, input logic p);
    integer i;
    @(posedge mclk);
    bit_out(1'b0);
    for (i = 0; i < 8; i++) begin
      bit_out(d[i]);
    end
    bit_out(p);
    bit_out(1'b1);
  endtask : send
  // too short to survive the start centre sample
  task automatic glitch();
    @(posedge mclk);
    line <= 1'b0;
    repeat (3) @(posedge mclk);
    line <= 1'b1;
  endtask : glitch
endmodule : umd_serial_station
`default_nettype wire

// ==== tb/tb_uart_receiver_multidrop.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_uart_receiver_multidrop;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        host_wr = 1'b0;
  logic        host_rd = 1'b0;
  logic        tick = 1'b0;
  logic        tx_active = 1'b0;
  logic [3:0]  host_addr = 4'h0;
  logic [7:0]  host_wdata = 8'h00;
  logic [1:0]  sample_mode = 2'h2;
  logic [7:0]  host_rdata;
  logic [15:0] divisor;
  logic        dir_pin;
  logic        ir_quarter_width;
  logic        line;
  logic [3:0]  frac;
  logic        irq;
  logic        pause_received;
  logic        resume_received;
  integer      pulses = 0;
  integer      failures = 0;
  integer      compares = 0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) tick <= ~tick;
  // flow pulses last one cycle: count them as they pass
  always @(posedge mclk) begin
    if (reset_n) pulses <= pulses + pause_received + resume_received;
  end
  umd_serial_station st (.mclk(mclk), .line(line));
  umd_receiver DUT (.mclk(mclk), .reset_n(reset_n), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata), .serial_in(line), .cts_pin_n(1'b1),
    .rts_level(1'b0), .tx_active(tx_active), .tx_holding_empty(1'b1),
    .tx_all_empty(1'b1), .modem_delta(4'h0), .sample_mode(sample_mode),
    .baud_tick(tick), .divisor(divisor), .frac_divisor(frac),
    .dir_pin(dir_pin), .ir_quarter_width(ir_quarter_width),
    .pause_received(pause_received), .resume_received(resume_received),
    .irq(irq));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge mclk);
    host_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge mclk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge mclk);
    host_rd <= 1'b0;
    @(posedge mclk);
    #1 chk(n, {8'h00, e}, {8'h00, host_rdata});
  endtask : rd
  task automatic close_out();
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(umd_pkg::OFS_MASK, 8'h00, "mask reset");
    rd(umd_pkg::OFS_LINE_ST, 8'h60, "status reset");
    wr(umd_pkg::OFS_MASK, 8'hE0);
    rd(umd_pkg::OFS_MASK, 8'h00, "mask locked");
    wr(umd_pkg::OFS_LINE_CTL, 8'h80);
    wr(umd_pkg::OFS_HOLD, 8'h34);
    wr(umd_pkg::OFS_MASK, 8'h12);
    wr(umd_pkg::OFS_SRC, 8'h93);
    repeat (2) @(posedge mclk);
    #1 chk("divisor", 16'h1234, divisor);
    chk("frac", 16'h0003, {12'h000, frac});
    chk("ir width", 16'h0001, {15'h0000, ir_quarter_width});
    chk("dir rx", 16'h0001, {15'h0000, dir_pin});
    @(posedge mclk);
    tx_active <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk("dir tx", 16'h0000, {15'h0000, dir_pin});
    wr(umd_pkg::OFS_LINE_CTL, 8'h3B);
    rd(umd_pkg::OFS_MASK, 8'h00, "divisor hidden");
    wr(umd_pkg::OFS_SRC, 8'h01);
    wr(umd_pkg::OFS_PAUSE1, 8'hA5);
    wr(umd_pkg::OFS_RESUME1, 8'hA5);
    st.send(8'hA5, 1'b0);
    repeat (10) @(posedge mclk);
    rd(umd_pkg::OFS_LINE_ST, 8'h61, "status ready");
    rd(umd_pkg::OFS_PAUSE1, 8'h03, "flow flags");
    chk("flow pulses", 16'h0002, pulses[15:0]);
    rd(umd_pkg::OFS_HOLD, 8'hA5, "byte");
    rd(umd_pkg::OFS_LINE_ST, 8'h60, "status empty");
    st.glitch();
    repeat (40) @(posedge mclk);
    rd(umd_pkg::OFS_LINE_ST, 8'h60, "false start");
    // below trigger: only the idle timer reports the byte
    wr(umd_pkg::OFS_RX_LEVEL, 8'h02);
    wr(umd_pkg::OFS_MASK, 8'h01);
    st.send(8'h3C, 1'b0);
    repeat (300) @(posedge mclk);
    rd(umd_pkg::OFS_SRC, 8'hC1, "no timeout yet");
    repeat (100) @(posedge mclk);
    rd(umd_pkg::OFS_SRC, 8'hCC, "timeout code");
    chk("timeout irq", 16'h0001, {15'h0000, irq});
    rd(umd_pkg::OFS_HOLD, 8'h3C, "timeout byte");
    rd(umd_pkg::OFS_SRC, 8'hC1, "timeout cleared");
    // normal multidrop with the receiver switched off
    wr(umd_pkg::OFS_LINE_CTL, 8'hBB);
    wr(umd_pkg::OFS_SRC, 8'h40);
    wr(umd_pkg::OFS_LINE_CTL, 8'h3B);
    wr(umd_pkg::OFS_MODEM, 8'h04);
    wr(umd_pkg::OFS_MASK, 8'h04);
    st.send(8'h55, 1'b0);
    st.send(8'h21, 1'b1);
    repeat (10) @(posedge mclk);
    rd(umd_pkg::OFS_SRC, 8'hC6, "line code");
    rd(umd_pkg::OFS_LINE_ST, 8'hE5, "address flags");
    chk("line irq", 16'h0000, {15'h0000, irq});
    rd(umd_pkg::OFS_HOLD, 8'h21, "address byte");
    rd(umd_pkg::OFS_LINE_ST, 8'h60, "data dropped");
    // automatic detection: only the slave address opens the receiver
    wr(umd_pkg::OFS_ENH, 8'h20);
    wr(umd_pkg::OFS_PAUSE2, 8'h21);
    st.send(8'h33, 1'b1);
    st.send(8'h21, 1'b1);
    st.send(8'h5A, 1'b0);
    repeat (10) @(posedge mclk);
    rd(umd_pkg::OFS_LINE_ST, 8'hE5, "auto address");
    rd(umd_pkg::OFS_HOLD, 8'h21, "auto match");
    rd(umd_pkg::OFS_HOLD, 8'h5A, "auto data");
    st.send(8'h44, 1'b1);
    st.send(8'h66, 1'b0);
    repeat (10) @(posedge mclk);
    rd(umd_pkg::OFS_LINE_ST, 8'h60, "auto mismatch");
    close_out();
  end
endmodule : tb_uart_receiver_multidrop
`default_nettype wire
